// *** verilog/cmp_params.svh ***
// constants for the comparator control register bank
// assumes 32-bit apb, one register per aligned word
`ifndef CMP_PARAMS_SVH
`define CMP_PARAMS_SVH

// register indices; byte address is four times the index
`define CMP_CTRL_IDX 8'h9A
`define CMP_MODE_IDX 8'h9C
`define CMP_MUX_IDX 8'h9F

`define CMP_CTRL_RST 8'h00
`define CMP_MODE_RST 8'h02
`define CMP_MUX_RST 8'h00

// control register fields
`define CTRL_EN_BIT 7
`define CTRL_OUT_BIT 6
`define CTRL_RISE_BIT 5
`define CTRL_FALL_BIT 4
`define CTRL_HYP_LSB 2
`define CTRL_HYN_LSB 0

// mode register fields
`define MODE_RIE_BIT 5
`define MODE_FIE_BIT 4
`define MODE_MD_LSB 0

// input select fields
`define MUX_NEG_LSB 4
`define MUX_POS_LSB 0

`define SYNC_STAGES 2

`endif

// *** verilog/cmp_pkg.sv ***
// types shared by the comparator control bank
// assumes cmp_params.svh holds the numbers
package cmp_pkg;

  typedef enum logic [1:0] {
    MODE_FASTEST,
    MODE_FAST,
    MODE_SLOW,
    MODE_SLOWEST
  } resp_mode_e;

  typedef enum logic [1:0] {
    HYST_OFF,
    HYST_5MV,
    HYST_10MV,
    HYST_20MV
  } hyst_e;

  typedef enum logic [1:0] {
    SEL_NONE,
    SEL_CTRL,
    SEL_MODE,
    SEL_MUX
  } reg_sel_e;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    logic cmpEnable;
    logic risingEdgeFlag;
    logic fallingEdgeFlag;
    hyst_e positiveHysteresisSel;
    hyst_e negativeHysteresisSel;
    logic risingEdgeIrqEnable;
    logic fallingEdgeIrqEnable;
    resp_mode_e responseModeSel;
    logic [2:0] negativeInputSel;
    logic [2:0] positiveInputSel;
    logic irqRequest;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } bank_s;

endpackage

// *** verilog/cmp_edge_sync.sv ***
// synchroniser and edge detector for the comparator output
// assumes cmpAsync is unrelated to core_clk
`timescale 1ns/1ps
`include "cmp_params.svh"

module cmp_edge_sync #(
  parameter int STAGES = `SYNC_STAGES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic cmpAsync,
  output logic cmpLevel,
  output logic risePulse,
  output logic fallPulse
);

  if (STAGES < 2) begin : g_bad_stages
    $error("cmp_edge_sync needs at least two stages");
  end

  typedef struct packed {
    logic [STAGES-1:0] sync;
    logic last;
  } sync_s;

  sync_s state;
  sync_s next_state;

  always_comb begin
    next_state = state;
    next_state.sync = {state.sync[STAGES-2:0], cmpAsync};
    next_state.last = state.sync[STAGES-1];
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign cmpLevel = state.sync[STAGES-1];
  assign risePulse = state.sync[STAGES-1] & ~state.last;
  assign fallPulse = ~state.sync[STAGES-1] & state.last;

endmodule

// *** verilog/comparator_ctrl_and_input_select.sv ***
// apb register bank for comparator control, mode and input select
// assumes an apb master on core_clk and an async comparator output
//
// Summary of operation
// - bit 6 of control shows live comparator result; writes ignored
// - output state reads 0 when positive input below negative
// - output state reads 1 when positive input above negative
// - rising edge sets bit 5 flag; stays until software writes 0
// - rising flag is 0 only if no rise since last clear
// - falling edge sets bit 4 flag; stays until software writes 0
// - bits 3:2 pick positive hysteresis: off, 5, 10, 20 mV
// - bits 1:0 pick negative hysteresis: off, 5, 10, 20 mV
// - rising edge requests interrupt only with mode bit 5 set
// - falling edge requests interrupt only with mode bit 4 set
// - mode bits 1:0 pick speed/power trade-off, sent to comparator
// - code 00 fastest and hungriest, 11 slowest and frugal
// - mode bits 7:6 and 3:2 read zero, writes ignored
// - control register sits at index 0x9A, no paging
// - input select routes pins to inputs; codes 101-111 reserved
// - input select bits 2:0 choose positive input
// - input select bits 6:4 choose negative input
// - input select bits 7 and 3 read zero, writes ignored
//
// Our own choice: the APB slave port.
`timescale 1ns/1ps
`include "cmp_params.svh"

module comparator_ctrl_and_input_select
  import cmp_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter int SYNC_STAGES = `SYNC_STAGES
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cmpAsync,
  output logic cmpEnable,
  output logic [1:0] positiveHysteresisSel,
  output logic [1:0] negativeHysteresisSel,
  output logic [1:0] responseModeSel,
  output logic [2:0] positiveInputSel,
  output logic [2:0] negativeInputSel,
  output logic irqRequest
);

  if (ADDR_W < 10) begin : g_bad_addr
    $error("ADDR_W too narrow for the register map");
  end

  localparam byte_t CTRL_RST = `CMP_CTRL_RST;
  localparam byte_t MODE_RST = `CMP_MODE_RST;
  localparam byte_t MUX_RST = `CMP_MUX_RST;

  localparam bank_s RESET_STATE = '{
    cmpEnable: CTRL_RST[`CTRL_EN_BIT],
    risingEdgeFlag: CTRL_RST[`CTRL_RISE_BIT],
    fallingEdgeFlag: CTRL_RST[`CTRL_FALL_BIT],
    positiveHysteresisSel: hyst_e'(CTRL_RST[`CTRL_HYP_LSB +: 2]),
    negativeHysteresisSel: hyst_e'(CTRL_RST[`CTRL_HYN_LSB +: 2]),
    risingEdgeIrqEnable: MODE_RST[`MODE_RIE_BIT],
    fallingEdgeIrqEnable: MODE_RST[`MODE_FIE_BIT],
    responseModeSel: resp_mode_e'(MODE_RST[`MODE_MD_LSB +: 2]),
    negativeInputSel: MUX_RST[`MUX_NEG_LSB +: 3],
    positiveInputSel: MUX_RST[`MUX_POS_LSB +: 3],
    irqRequest: 1'b0,
    pready: 1'b0,
    pslverr: 1'b0,
    prdata: 32'h0000_0000
  };

  bank_s state;
  bank_s next_state;

  logic cmpLevel;
  logic risePulse;
  logic fallPulse;

  cmp_edge_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .cmpAsync(cmpAsync),
    .cmpLevel(cmpLevel),
    .risePulse(risePulse),
    .fallPulse(fallPulse)
  );

  function automatic reg_sel_e decodeReg(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] ctrlAddr;
    logic [ADDR_W-1:0] modeAddr;
    logic [ADDR_W-1:0] muxAddr;
    ctrlAddr = ADDR_W'({`CMP_CTRL_IDX, 2'b00});
    modeAddr = ADDR_W'({`CMP_MODE_IDX, 2'b00});
    muxAddr = ADDR_W'({`CMP_MUX_IDX, 2'b00});
    if (addr == ctrlAddr) begin
      return SEL_CTRL;
    end else if (addr == modeAddr) begin
      return SEL_MODE;
    end else if (addr == muxAddr) begin
      return SEL_MUX;
    end else begin
      return SEL_NONE;
    end
  endfunction

  logic setupPhase;
  logic accessDone;
  logic wrCtrl;
  logic wrMode;
  logic wrMux;
  reg_sel_e setupSel;
  reg_sel_e accessSel;
  byte_t ctrlView;
  byte_t modeView;
  byte_t muxView;
  byte_t readByte;

  assign setupPhase = psel & ~penable;
  assign accessDone = psel & penable & state.pready;
  assign setupSel = decodeReg(paddr);
  assign accessSel = decodeReg(paddr);
  assign wrCtrl = accessDone & pwrite & (accessSel == SEL_CTRL);
  assign wrMode = accessDone & pwrite & (accessSel == SEL_MODE);
  assign wrMux = accessDone & pwrite & (accessSel == SEL_MUX);

  // register read images
  always_comb begin
    ctrlView = 8'h00;
    ctrlView[`CTRL_OUT_BIT] = cmpLevel;
    ctrlView[`CTRL_EN_BIT] = state.cmpEnable;
    ctrlView[`CTRL_RISE_BIT] = state.risingEdgeFlag;
    ctrlView[`CTRL_FALL_BIT] = state.fallingEdgeFlag;
    ctrlView[`CTRL_HYP_LSB +: 2] = state.positiveHysteresisSel;
    ctrlView[`CTRL_HYN_LSB +: 2] = state.negativeHysteresisSel;
    modeView = 8'h00;
    modeView[`MODE_RIE_BIT] = state.risingEdgeIrqEnable;
    modeView[`MODE_FIE_BIT] = state.fallingEdgeIrqEnable;
    modeView[`MODE_MD_LSB +: 2] = state.responseModeSel;
    muxView = 8'h00;
    muxView[`MUX_NEG_LSB +: 3] = state.negativeInputSel;
    muxView[`MUX_POS_LSB +: 3] = state.positiveInputSel;
    case (setupSel)
      SEL_CTRL: readByte = ctrlView;
      SEL_MODE: readByte = modeView;
      SEL_MUX: readByte = muxView;
      default: readByte = 8'h00;
    endcase
  end

  always_comb begin
    next_state = state;
    // apb: ready in the cycle after setup, one wait-free access
    next_state.pready = setupPhase;
    if (setupPhase) begin
      next_state.prdata = {24'h00_0000, readByte};
      next_state.pslverr = (setupSel == SEL_NONE);
    end
    if (accessDone) begin
      next_state.pslverr = 1'b0;
    end
    if (wrCtrl) begin
      next_state.cmpEnable = pwdata[`CTRL_EN_BIT];
      next_state.positiveHysteresisSel = hyst_e'(pwdata[`CTRL_HYP_LSB +: 2]);
      next_state.negativeHysteresisSel = hyst_e'(pwdata[`CTRL_HYN_LSB +: 2]);
      next_state.risingEdgeFlag = pwdata[`CTRL_RISE_BIT];
      next_state.fallingEdgeFlag = pwdata[`CTRL_FALL_BIT];
    end
    if (risePulse) begin
      next_state.risingEdgeFlag = 1'b1;
    end
    if (fallPulse) begin
      next_state.fallingEdgeFlag = 1'b1;
    end
    if (wrMode) begin
      next_state.risingEdgeIrqEnable = pwdata[`MODE_RIE_BIT];
      next_state.fallingEdgeIrqEnable = pwdata[`MODE_FIE_BIT];
      // response mode to the analog core
      next_state.responseModeSel = resp_mode_e'(pwdata[`MODE_MD_LSB +: 2]);
    end
    if (wrMux) begin
      next_state.positiveInputSel = pwdata[`MUX_POS_LSB +: 3];
      next_state.negativeInputSel = pwdata[`MUX_NEG_LSB +: 3];
    end
    next_state.irqRequest =
      (next_state.risingEdgeFlag & next_state.risingEdgeIrqEnable) |
      (next_state.fallingEdgeFlag & next_state.fallingEdgeIrqEnable);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= RESET_STATE;
    end else begin
      state <= next_state;
    end
  end

  assign prdata = state.prdata;
  assign pready = state.pready;
  assign pslverr = state.pslverr;
  assign cmpEnable = state.cmpEnable;
  assign positiveHysteresisSel = state.positiveHysteresisSel;
  assign negativeHysteresisSel = state.negativeHysteresisSel;
  assign responseModeSel = state.responseModeSel;
  assign positiveInputSel = state.positiveInputSel;
  assign negativeInputSel = state.negativeInputSel;
  assign irqRequest = state.irqRequest;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (sys_rst);

  a_enable_write: assert property (
    wrCtrl |=> cmpEnable == $past(pwdata[`CTRL_EN_BIT])
  ) else $error("enable bit did not follow write");

  a_enable_hold: assert property (
    !wrCtrl |=> $stable(cmpEnable)
  ) else $error("enable changed without a write");

  // state bit read back equals synced level
  a_state_read: assert property (
    setupPhase && setupSel == SEL_CTRL
      |=> prdata[`CTRL_OUT_BIT] == $past(cmpLevel) && pready
  ) else $error("output state read wrong");

  a_state_low: assert property (
    setupPhase && setupSel == SEL_CTRL && !cmpLevel
      |=> !prdata[`CTRL_OUT_BIT]
  ) else $error("output state not zero");

  a_state_high: assert property (
    setupPhase && setupSel == SEL_CTRL && cmpLevel
      |=> prdata[`CTRL_OUT_BIT]
  ) else $error("output state not one");

  // rising edge sets flag next cycle
  a_rise_set: assert property (
    risePulse |=> state.risingEdgeFlag
  ) else $error("rising flag not set");

  a_rise_sticky: assert property (
    state.risingEdgeFlag && !(wrCtrl && !pwdata[`CTRL_RISE_BIT])
      |=> state.risingEdgeFlag
  ) else $error("rising flag dropped");

  // no event, no write: stays clear
  a_rise_clear: assert property (
    !state.risingEdgeFlag && !risePulse && !wrCtrl
      |=> !state.risingEdgeFlag
  ) else $error("rising flag set with no edge");

  // falling edge sets flag; still set two cycles later if no control write between
  a_fall_set: assert property (
    fallPulse ##1 !wrCtrl |=> state.fallingEdgeFlag [*1]
  ) else $error("falling flag not held");

  // falling flag sticky until written zero
  a_fall_sticky: assert property (
    state.fallingEdgeFlag && !(wrCtrl && !pwdata[`CTRL_FALL_BIT])
      |=> state.fallingEdgeFlag
  ) else $error("falling flag dropped");

  a_hyp_write: assert property (
    wrCtrl |=> positiveHysteresisSel == $past(pwdata[`CTRL_HYP_LSB +: 2])
  ) else $error("positive hysteresis wrong");

  a_hyn_write: assert property (
    wrCtrl |=> negativeHysteresisSel == $past(pwdata[`CTRL_HYN_LSB +: 2])
  ) else $error("negative hysteresis wrong");

  a_irq_gate: assert property (
    irqRequest |-> (state.risingEdgeFlag && state.risingEdgeIrqEnable) ||
      (state.fallingEdgeFlag && state.fallingEdgeIrqEnable)
  ) else $error("interrupt without enabled flag");

  a_irq_fall: assert property (
    fallPulse && state.fallingEdgeIrqEnable && !wrMode |=> irqRequest
  ) else $error("falling interrupt missed");

  a_irq_rise: assert property (
    risePulse && state.risingEdgeIrqEnable && !wrMode |=> irqRequest
  ) else $error("rising interrupt missed");

  a_mode_write: assert property (
    wrMode |=> responseModeSel == $past(pwdata[`MODE_MD_LSB +: 2])
  ) else $error("response mode wrong");

  a_mode_unused: assert property (
    setupPhase && setupSel == SEL_MODE |=> prdata[7:6] == 2'b00 && prdata[3:2] == 2'b00
  ) else $error("mode unused bits not zero");

  a_ctrl_decode: assert property (
    setupPhase && setupSel == SEL_CTRL |=> pready && !pslverr
  ) else $error("control register not decoded");

  a_pos_sel: assert property (
    wrMux |=> positiveInputSel == $past(pwdata[2:0])
  ) else $error("positive select wrong");

  a_neg_sel: assert property (
    wrMux |=> negativeInputSel == $past(pwdata[6:4])
  ) else $error("negative select wrong");

  a_sel_hold: assert property (
    !wrMux |=> $stable(positiveInputSel) && $stable(negativeInputSel)
  ) else $error("input select changed without a write");

  a_mux_unused: assert property (
    setupPhase && setupSel == SEL_MUX |=> !prdata[7] && !prdata[3]
  ) else $error("select unused bits not zero");

endmodule

// *** tb/tb.sv ***
// testbench for the comparator control and input select register bank
// assumes the design files and cmp_params.svh are compiled first
`timescale 1ns/1ps
`include "cmp_params.svh"

module tb
  import cmp_pkg::*;
;
  localparam logic [11:0] CTRL_A = 12'(`CMP_CTRL_IDX * 4);
  localparam logic [11:0] MODE_A = 12'(`CMP_MODE_IDX * 4);
  localparam logic [11:0] MUX_A = 12'(`CMP_MUX_IDX * 4);

  typedef struct {
    logic [11:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdExp;
    logic errExp;
    logic [13:0] outExp;
  } row_s;

  logic core_clk;
  logic sys_rst;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cmpAsync;
  logic cmpEnable;
  logic [1:0] positiveHysteresisSel;
  logic [1:0] negativeHysteresisSel;
  logic [1:0] responseModeSel;
  logic [2:0] positiveInputSel;
  logic [2:0] negativeInputSel;
  logic irqRequest;
  logic [31:0] rdData;
  logic rdErr;
  logic [13:0] outVec;
  int errCount;
  int cmpCount;

  // expected output vector: irq, enable, hyst+, hyst-, mode, pos sel, neg sel
  row_s rows[13] = '{
    '{CTRL_A, 8'hC7, 8'h87, 1'h0, 14'h1780},
    '{CTRL_A, 8'h0E, 8'h0E, 1'h0, 14'h0E80},
    '{CTRL_A, 8'h88, 8'h88, 1'h0, 14'h1880},
    '{MODE_A, 8'hFF, 8'h33, 1'h0, 14'h18C0},
    '{MODE_A, 8'hC0, 8'h00, 1'h0, 14'h1800},
    '{MODE_A, 8'h01, 8'h01, 1'h0, 14'h1840},
    '{MODE_A, 8'h0E, 8'h02, 1'h0, 14'h1880},
    '{MUX_A, 8'hFF, 8'h77, 1'h0, 14'h18BF},
    '{MUX_A, 8'h0C, 8'h04, 1'h0, 14'h18A0},
    '{MUX_A, 8'h32, 8'h32, 1'h0, 14'h1893},
    '{12'h26C, 8'hFF, 8'h00, 1'h1, 14'h1893},
    '{12'h09A, 8'h00, 8'h00, 1'h1, 14'h1893},
    '{CTRL_A, 8'h85, 8'h85, 1'h0, 14'h1593}
  };

  comparator_ctrl_and_input_select #(
    .ADDR_W(12)
  ) i_dut (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .cmpAsync(cmpAsync),
    .cmpEnable(cmpEnable),
    .positiveHysteresisSel(positiveHysteresisSel),
    .negativeHysteresisSel(negativeHysteresisSel),
    .responseModeSel(responseModeSel),
    .positiveInputSel(positiveInputSel),
    .negativeInputSel(negativeInputSel),
    .irqRequest(irqRequest)
  );

  initial begin
    core_clk = 1'h0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmpCount, errCount);
    if (errCount == 0 && cmpCount > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer; entered just after a rising edge, leaves psel up
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= 32'(d);
    @(posedge core_clk);
    penable <= 1'h1;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (pready === 1'h1) break;
    end
    if (n == 20) begin
      errCount++;
      finish_test();
    end else begin
      rdData = prdata;
      rdErr = pslverr;
      outVec = {irqRequest, cmpEnable, positiveHysteresisSel, negativeHysteresisSel, responseModeSel,
                positiveInputSel, negativeInputSel};
    end
  endtask

  task automatic idle();
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge core_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    xfer(1'h1, a, d);
    idle();
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e, input logic er, input logic [13:0] o);
    xfer(1'h0, a, 8'h00);
    idle();
    chk(rdData, 32'(e));
    chk(32'(rdErr), 32'(er));
    chk(32'(outVec), 32'(o));
  endtask

  task automatic reset_chk();
    sys_rst <= 1'h1;
    cmpAsync <= 1'h0;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'h0;
    rd_chk(CTRL_A, 8'h00, 1'h0, 14'h0080);
    rd_chk(MODE_A, 8'h02, 1'h0, 14'h0080);
    rd_chk(MUX_A, 8'h00, 1'h0, 14'h0080);
  endtask

  initial begin
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    errCount = 0;
    cmpCount = 0;
    reset_chk();
    // chosen pins taken as analog, crossbar-skipped
    foreach (rows[i]) begin
      wr(rows[i].addr, rows[i].wrData);
      rd_chk(rows[i].addr, rows[i].rdExp, rows[i].errExp, rows[i].outExp);
    end
    wr(MODE_A, 8'h30);
    wr(CTRL_A, 8'h80);
    cmpAsync <= 1'h1;
    repeat (6) @(posedge core_clk);
    rd_chk(CTRL_A, 8'hE0, 1'h0, 14'h3013);
    wr(CTRL_A, 8'h80);
    repeat (6) @(posedge core_clk);
    rd_chk(CTRL_A, 8'hC0, 1'h0, 14'h1013);
    cmpAsync <= 1'h0;
    repeat (6) @(posedge core_clk);
    rd_chk(CTRL_A, 8'h90, 1'h0, 14'h3013);
    wr(MODE_A, 8'h20);
    rd_chk(MODE_A, 8'h20, 1'h0, 14'h1013);
    wr(CTRL_A, 8'h80);
    wr(MODE_A, 8'h10);
    cmpAsync <= 1'h1;
    repeat (6) @(posedge core_clk);
    rd_chk(CTRL_A, 8'hE0, 1'h0, 14'h1013);
    wr(CTRL_A, 8'h00);
    rd_chk(CTRL_A, 8'h40, 1'h0, 14'h0013);
    // back-to-back write then read, no idle between
    xfer(1'h1, CTRL_A, 8'h8C);
    xfer(1'h0, CTRL_A, 8'h00);
    idle();
    chk(rdData, 32'h0000_00CC);
    chk(32'(outVec), 32'h0000_1C13);
    reset_chk();
    finish_test();
  end
endmodule
